// ---- hw/sfq_cmd.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - Command 42h plus 24-bit address and 1 to 256 bytes programs a security register.
// - Programming of a security register needs the write enable latch set.
// - Address: top byte zero, bits 15:12 pick register 1 to 3, 11:8 zero.
// - A locked security register ignores program commands.
// - Command 48h: opcode and address on rising edges, eight dummies, data on falling.
// - Read offset increments and wraps FFh to 00h inside the same register.
// - A security read while busy is ignored and leaves the cycle alone.
// - Read parameter command C0h only works in quad command mode.
// - Dummy select 0 to 3 gives 2, 4, 6, 8 dummy clocks.
// - Wrap select 0 to 3 gives 8, 16, 32, 64 byte wrap.
// - After power-up or reset: wrap 8 bytes, 2 dummy clocks.
// - Programmed dummies apply to 0Bh, EBh, 0Ch in quad mode only.
// - In SPI mode 77h sets the wrap; it survives entering quad mode.
// - Wrapped read 0Ch stays inside its aligned wrap window.
// - Power-up in SPI; 38h enters quad mode only with quad enable set.
// - FFh leaves quad mode; only one mode at a time.
// - Mode switches keep write enable and wrap setting.
// - Reset needs 66h then 99h; any other command disarms it.
// - Accepted reset aborts work and restores all volatile defaults.
// - Reset takes about 30 us and accepts no command meanwhile.
module sfq_cmd #(
	parameter int RST_CYCLES = sfq_pkg::RST_CYC,
	parameter int PROG_CYCLES = sfq_pkg::PROG_CYC_DEF
) (
	// System clock and reset.
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	// Serial link pins.
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic [3:0] IO_IN,
	output logic [3:0] IO_OUT,
	output logic [3:0] IO_OE_N,
	// Status register bits and block state.
	input wire logic QUAD_ENABLE_BIT,
	input wire logic [2:0] SECURITY_LOCK_BITS,
	output sfq_pkg::sfq_stat_t STATUS,
	// Main array read port.
	output logic [23:0] ARR_ADDR,
	input wire logic [7:0] ARR_DATA
);
	import sfq_pkg::*;

	if (RST_CYCLES < 1 || RST_CYCLES > 65535 || PROG_CYCLES < 1 || PROG_CYCLES > 65535)
	begin : g_bad
		$error("Cycle counts must lie in 1 to 65535.");
	end

	// ********************************************************
	// Helpers.
	// ********************************************************
	function automatic logic [15:0] dummy_clocks(input logic [1:0] sel);
		dummy_clocks = {13'h0, sel, 1'b0} + 16'h0002;
	endfunction : dummy_clocks

	function automatic logic sec_ok(input logic [23:0] a);
		sec_ok = a[23:16] == 8'h00 && a[11:8] == 4'h0 && a[15:12] >= 4'h1 && a[15:12] <= 4'h3;
	endfunction : sec_ok

	function automatic logic [9:0] sec_idx(input logic [23:0] a);
		sec_idx = {2'(a[13:12] - 2'h1), a[7:0]};
	endfunction : sec_idx

	function automatic logic [23:0] rd_next(input logic [7:0] op, input logic [23:0] a, input logic [1:0] w);
		logic [23:0] m;
		m = (24'h000008 << w) - 24'h000001;
		if (op == OP_SREAD)
			rd_next = {a[23:8], 8'(a[7:0] + 8'h01)};
		else if (op == OP_WRAPRD)
			rd_next = (a & ~m) | ((a + 24'h000001) & m);
		else
			rd_next = a + 24'h000001;
	endfunction : rd_next

	// ********************************************************
	// Link clock domain.
	// ********************************************************
	logic [3:0] lk_nib_q;
	logic lk_tog_q;
	logic [3:0] lk_out_q;
	logic [3:0] lk_oen_q;
	logic [3:0] out_q;
	logic [3:0] oen_q;
	logic lk_clr;

	// Chip select rising clears the launch stage, since the clock stops and a stale enable would clash later.
	assign lk_clr = SYS_RST | CS_N;

	// Input lines are taken on rising edges; the toggle marks each edge for the system side.
	always_ff @(posedge SCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			lk_nib_q <= 4'h0;
			lk_tog_q <= 1'b0;
		end
		else
		begin
			lk_nib_q <= IO_IN;
			lk_tog_q <= ~lk_tog_q;
		end
	end

	// Output bits are prepared on the system side well before the falling edge that launches them.
	always_ff @(negedge SCLK or posedge lk_clr)
	begin
		if (lk_clr)
		begin
			lk_out_q <= 4'h0;
			lk_oen_q <= 4'hF;
		end
		else
		begin
			lk_out_q <= out_q;
			lk_oen_q <= oen_q;
		end
	end

	// The pins are released whenever chip select is high, since the link clock stops then.
	assign IO_OUT = lk_out_q;
	assign IO_OE_N = lk_oen_q | {4{CS_N}};

	// ********************************************************
	// Crossing into the system domain.
	// ********************************************************
	logic [2:0] tg_q;
	logic [4:0] cs_q;
	logic ev;
	logic fend;

	// Chip select runs two stages later than the toggle so the last edge is handled first.
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			tg_q <= 3'h0;
			cs_q <= 5'h1F;
		end
		else
		begin
			tg_q <= {tg_q[1:0], lk_tog_q};
			cs_q <= {cs_q[3:0], CS_N};
		end
	end

	assign ev = tg_q[1] ^ tg_q[2];
	assign fend = cs_q[3] & ~cs_q[4];

	// ********************************************************
	// Frame decode.
	// ********************************************************
	sfq_state_t state_q;
	logic [15:0] n_q, n_d, oc, ae, hdr, cnt_q;
	logic [31:0] sh_q, sh_d;
	logic [7:0] opcode_q, pi_q, poff_q, ob_q, ob_d;
	logic [23:0] addr_q, rd_addr_q, psel_q;
	logic qpi_q, wel_q, rst_en_q, rd_act_q, pany_q, byte_done, pwr, rd_ok, rd_start, rd_load;
	logic one_byte, acc, go_rst, go_prog, prog_end;
	logic [1:0] dummy_q, wrap_q;
	logic [3:0] left_q;
	logic [255:0] pmask_q;
	logic [7:0] pbuf [0:255];
	logic [7:0] sec_mem [0:SEC_WORDS-1];

	// Shift width, header length and read permission follow the current mode.
	always_comb
	begin
		oc = qpi_q ? CLK_BYTE_QPI : CLK_BYTE_SPI;
		ae = oc << 2;
		sh_d = qpi_q ? {sh_q[27:0], lk_nib_q} : {sh_q[30:0], lk_nib_q[0]};
		n_d = (n_q == NO_HDR) ? n_q : n_q + 16'h0001;
		byte_done = n_d > ae && ((n_d - ae) & (oc - 16'h0001)) == 16'h0000;
		pwr = byte_done && opcode_q == OP_PROG && !qpi_q && state_q == ST_IDLE;
		case (opcode_q)
			OP_SREAD: hdr = ae + SPI_DUMMY;
			OP_FAST: hdr = ae + (qpi_q ? dummy_clocks(dummy_q) : SPI_DUMMY);
			OP_QIO, OP_WRAPRD: hdr = ae + dummy_clocks(dummy_q);
			default: hdr = NO_HDR;
		endcase
		case (opcode_q)
			OP_SREAD: rd_ok = !qpi_q && sec_ok(addr_q);
			OP_FAST: rd_ok = 1'b1;
			OP_QIO, OP_WRAPRD: rd_ok = qpi_q;
			default: rd_ok = 1'b0;
		endcase
		rd_ok = rd_ok && state_q == ST_IDLE;
		rd_start = ev && n_d == hdr && rd_ok;
		rd_load = rd_start || (rd_act_q && left_q == 4'h0);
		ob_d = rd_load ? ((opcode_q == OP_SREAD) ? sec_mem[sec_idx(rd_addr_q)] : ARR_DATA)
			: (qpi_q ? {ob_q[3:0], 4'h0} : {ob_q[6:0], 1'b0});
	end

	// Bit counter, shifter, opcode and address of the running frame.
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST || fend)
		begin
			n_q <= 16'h0000;
			sh_q <= 32'h0;
			opcode_q <= OP_NONE;
			addr_q <= 24'h0;
		end
		else if (ev)
		begin
			n_q <= n_d;
			sh_q <= sh_d;
			if (n_d == oc)
				opcode_q <= sh_d[7:0];
			if (n_d == ae)
				addr_q <= sh_d[23:0];
		end
	end

	// ********************************************************
	// Program staging.
	// ********************************************************
	always_ff @(posedge REF_CLK)
	begin
		if (ev && pwr)
			pbuf[poff_q] <= sh_d[7:0];
	end

	// Offsets wrap within the page, so more than 256 bytes keep the last ones sent.
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			pmask_q <= '0;
			poff_q <= 8'h00;
			pany_q <= 1'b0;
		end
		else if (ev && state_q == ST_IDLE)
		begin
			if (n_d == oc)
			begin
				pmask_q <= '0;
				pany_q <= 1'b0;
			end
			if (n_d == ae)
				poff_q <= sh_d[7:0];
			if (pwr)
			begin
				pmask_q[poff_q] <= 1'b1;
				pany_q <= 1'b1;
				poff_q <= poff_q + 8'h01;
			end
		end
	end

	// Programming only clears bits, so erased bytes take the data and others keep a mix.
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			for (int i = 0; i < SEC_WORDS; i++)
				sec_mem[i] <= ERASED;
		end
		else if (state_q == ST_PROG && pmask_q[pi_q])
			sec_mem[sec_idx({psel_q[23:8], pi_q})] <= sec_mem[sec_idx({psel_q[23:8], pi_q})] & pbuf[pi_q];
	end

	// ********************************************************
	// Read data path.
	// ********************************************************
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST || fend)
		begin
			rd_act_q <= 1'b0;
			rd_addr_q <= 24'h0;
			ob_q <= 8'h00;
			left_q <= 4'h0;
			out_q <= 4'h0;
			oen_q <= 4'hF;
		end
		else if (ev)
		begin
			if (n_d == ae)
				rd_addr_q <= sh_d[23:0];
			if (rd_start || rd_act_q)
			begin
				rd_act_q <= 1'b1;
				ob_q <= ob_d;
				left_q <= rd_load ? (qpi_q ? 4'h4 : 4'h7) : left_q - (qpi_q ? 4'h4 : 4'h1);
				if (rd_load)
					rd_addr_q <= rd_next(opcode_q, rd_addr_q, wrap_q);
				out_q <= qpi_q ? ob_d[7:4] : {2'b00, ob_d[7], 1'b0};
				oen_q <= qpi_q ? 4'h0 : 4'hD;
			end
		end
	end

	assign ARR_ADDR = rd_addr_q;

	// ********************************************************
	// Command completion and sequencing.
	// ********************************************************
	always_comb
	begin
		one_byte = n_q == oc;
		acc = fend && state_q != ST_RST;
		go_rst = acc && one_byte && opcode_q == OP_RST && rst_en_q;
		go_prog = acc && state_q == ST_IDLE && opcode_q == OP_PROG && !qpi_q && wel_q && pany_q
			&& sec_ok(addr_q) && !SECURITY_LOCK_BITS[2'(addr_q[13:12] - 2'h1)]
			&& n_q > ae && ((n_q - ae) & (CLK_BYTE_SPI - 16'h0001)) == 16'h0000;
		prog_end = state_q == ST_WAIT && cnt_q == 16'h0000;
	end

	// Program walk, self-timed wait and reset interval; a reset aborts the walk or the wait.
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 16'h0000;
			pi_q <= 8'h00;
			psel_q <= 24'h0;
		end
		else if (go_rst)
		begin
			state_q <= ST_RST;
			cnt_q <= 16'(RST_CYCLES - 1);
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (go_prog)
					begin
						state_q <= ST_PROG;
						pi_q <= 8'h00;
						psel_q <= addr_q;
					end
				end
				ST_PROG:
				begin
					pi_q <= pi_q + 8'h01;
					if (pi_q == 8'hFF)
					begin
						state_q <= ST_WAIT;
						cnt_q <= 16'(PROG_CYCLES - 1);
					end
				end
				ST_WAIT, ST_RST:
				begin
					if (cnt_q == 16'h0000)
						state_q <= ST_IDLE;
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Volatile settings; mode changes touch only the mode bit and the reset arm.
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST || go_rst)
		begin
			wel_q <= 1'b0;
			qpi_q <= 1'b0;
			dummy_q <= DUMMY_RST;
			wrap_q <= WRAP_RST;
			rst_en_q <= 1'b0;
		end
		else
		begin
			if (prog_end)
				wel_q <= 1'b0;
			if (acc)
			begin
				rst_en_q <= one_byte && opcode_q == OP_RST_EN;
				if (state_q == ST_IDLE)
				begin
					case (opcode_q)
						OP_WREN: if (one_byte) wel_q <= 1'b1;
						OP_QPI_ON: if (one_byte && QUAD_ENABLE_BIT) qpi_q <= 1'b1;
						OP_QPI_OFF: if (one_byte && qpi_q) qpi_q <= 1'b0;
						OP_PARAM:
						begin
							if (qpi_q && n_q == (oc << 1))
							begin
								dummy_q <= sh_q[P_DUMMY_LSB +: 2];
								wrap_q <= sh_q[P_WRAP_LSB +: 2];
							end
						end
						OP_WRAPSET: if (!qpi_q && n_q == ae + CLK_BYTE_SPI) wrap_q <= sh_q[W_WRAP_LSB +: 2];
						default: wel_q <= wel_q;
					endcase
				end
			end
		end
	end

	assign STATUS = '{busy: state_q != ST_IDLE, write_enable_latch: wel_q, quad_command_mode: qpi_q,
		reset_armed: rst_en_q, dummy_select_field: dummy_q, wrap_select_field: wrap_q};

	// ********************************************************
	// Checks.
	// ********************************************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);

	a_wel_gate: assert property (fend && state_q == ST_IDLE && opcode_q == OP_PROG && !wel_q
		|=> state_q == ST_IDLE) else $error("Program taken without write enable.");
	a_lock_block: assert property (fend && state_q == ST_IDLE && opcode_q == OP_PROG && sec_ok(addr_q)
		&& SECURITY_LOCK_BITS[2'(addr_q[13:12] - 2'h1)] |=> state_q == ST_IDLE) else $error("Locked register programmed.");
	a_prog_cycle: assert property (go_prog |=> state_q == ST_PROG ##256 state_q == ST_WAIT && wel_q)
		else $error("Program walk length wrong.");
	a_rd_busy: assert property (ev && n_d == hdr && opcode_q == OP_SREAD && state_q != ST_IDLE
		|=> !rd_act_q) else $error("Security read served while busy.");
	a_sec_wrap: assert property (ev && rd_act_q && left_q == 4'h0 && opcode_q == OP_SREAD
		&& rd_addr_q[7:0] == 8'hFF |=> rd_addr_q[7:0] == 8'h00 && $stable(rd_addr_q[15:8]))
		else $error("Security offset did not wrap in place.");
	a_param_spi: assert property (fend && opcode_q == OP_PARAM && !qpi_q
		|=> $stable(dummy_q) && $stable(wrap_q)) else $error("Read parameters changed in SPI mode.");
	a_qpi_gate: assert property (acc && state_q == ST_IDLE && opcode_q == OP_QPI_ON && one_byte && !qpi_q
		|=> qpi_q == $past(QUAD_ENABLE_BIT)) else $error("Quad mode entry ignored the enable bit.");
	a_reset_dflt: assert property (go_rst |=> dummy_q == DUMMY_RST && wrap_q == WRAP_RST
		&& !wel_q && state_q == ST_RST) else $error("Reset defaults not restored.");
	a_reset_time: assert property ($rose(state_q == ST_RST) |-> cnt_q == 16'(RST_CYCLES - 1))
		else $error("Reset interval length wrong.");
	a_mode_keep: assert property ($changed(qpi_q) && !$past(go_rst) |-> $stable(wel_q) && $stable(wrap_q))
		else $error("Mode switch disturbed settings.");
	a_wrap_window: assert property (ev && rd_act_q && left_q == 4'h0 && opcode_q == OP_WRAPRD
		|=> rd_addr_q[23:6] == $past(rd_addr_q[23:6])) else $error("Wrapped read left its window.");

	c_prog: cover property (go_prog);
	c_sread: cover property (rd_start && opcode_q == OP_SREAD);
	c_qpi: cover property ($rose(qpi_q));
	c_reset: cover property (go_rst);
endmodule : sfq_cmd

// ---- common/sfq_pkg.sv ----
package sfq_pkg;
	// ********************************************************
	// Command codes.
	// ********************************************************
	localparam logic [7:0] OP_NONE = 8'h00;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_PROG = 8'h42;
	localparam logic [7:0] OP_SREAD = 8'h48;
	localparam logic [7:0] OP_PARAM = 8'hC0;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_QIO = 8'hEB;
	localparam logic [7:0] OP_WRAPRD = 8'h0C;
	localparam logic [7:0] OP_WRAPSET = 8'h77;
	localparam logic [7:0] OP_QPI_ON = 8'h38;
	localparam logic [7:0] OP_QPI_OFF = 8'hFF;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	// ********************************************************
	// Framing, fields and defaults.
	// ********************************************************
	localparam logic [15:0] CLK_BYTE_SPI = 16'h0008;
	localparam logic [15:0] CLK_BYTE_QPI = 16'h0002;
	localparam logic [15:0] SPI_DUMMY = 16'h0008;
	localparam logic [15:0] NO_HDR = 16'hFFFF;
	localparam int P_DUMMY_LSB = 4;
	localparam int P_WRAP_LSB = 0;
	localparam int W_WRAP_LSB = 4;
	localparam logic [1:0] DUMMY_RST = 2'h0;
	localparam logic [1:0] WRAP_RST = 2'h0;
	localparam logic [7:0] ERASED = 8'hFF;
	localparam int SEC_WORDS = 768;
	// ********************************************************
	// Timing.
	// ********************************************************
	localparam int T_RST_NS = 30000;
	localparam int REF_MHZ = 250;
	localparam int RST_CYC = (T_RST_NS * REF_MHZ) / 1000;
	localparam int PROG_CYC_DEF = 1000;
	// ********************************************************
	// Types.
	// ********************************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_PROG = 4'h2,
		ST_WAIT = 4'h4,
		ST_RST = 4'h8
	} sfq_state_t;
	typedef struct packed {
		logic busy;
		logic write_enable_latch;
		logic quad_command_mode;
		logic reset_armed;
		logic [1:0] dummy_select_field;
		logic [1:0] wrap_select_field;
	} sfq_stat_t;
endpackage : sfq_pkg

// ---- tb/sfq_host_model.sv ----
`timescale 1ns/10ps
// ****************************************
// Host controller at the far end of the link.
// ****************************************
module sfq_host_model (
	// Link pins seen from the host.
	output logic sclk,
	output logic cs_n,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n
);
	logic [3:0] q;
	logic [3:0] oe_q;
	// The clock stands low and select high outside frames.
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
	end
	// One clock: data is set while low and taken at the rising edge.
	task automatic tick(input logic [3:0] d);
	begin
		io_in = d;
		#80;
		// Released lines read back inverted, so a missing drive never passes as data.
		q = io_out ^ io_oe_n;
		oe_q = io_oe_n;
		sclk = 1'b1;
		#80;
		sclk = 1'b0;
	end
	endtask : tick
	// Whole bytes MSB first, then dummies, then read bytes; unused lines toggle so stale values never pass.
	task automatic frame(input bit quad, input logic [63:0] tx, input int ntx, input int ndum, input int nrd,
		output logic [31:0] rx, output logic [3:0] oe);
		int w;
	begin
		w = quad ? 4 : 1;
		rx = 32'h0;
		// A small offset keeps link edges off the system clock edges.
		#1.3;
		cs_n = 1'b0;
		for (int i = ntx * 8 - w; i >= 0; i -= w)
			tick(quad ? tx[i +: 4] : {~io_in[3:1], tx[i]});
		for (int i = 0; i < ndum; i++)
			tick(~io_in);
		for (int i = 0; i < nrd * 8; i += w)
		begin
			tick(~io_in);
			rx = quad ? {rx[27:0], q} : {rx[30:0], q[1]};
		end
		oe = oe_q;
		#80;
		cs_n = 1'b1;
		io_in = ~io_in;
		// Deselect gap well above the minimum so the frame is executed first.
		#200;
	end
	endtask : frame
endmodule : sfq_host_model

// ---- tb/sfq_cmd_test.sv ----
`timescale 1ns/10ps
module sfq_cmd_test;
	import sfq_pkg::*;
	localparam int PROG_N = 3000;
	localparam int RST_N = 600;
	logic REF_CLK = 1'b0;
	logic SYS_RST = 1'b0;
	logic QUAD_ENABLE_BIT = 1'b0;
	logic [2:0] SECURITY_LOCK_BITS = 3'h0;
	logic SCLK;
	logic CS_N;
	logic [3:0] IO_IN;
	logic [3:0] IO_OUT;
	logic [3:0] IO_OE_N;
	sfq_stat_t STATUS;
	logic [23:0] ARR_ADDR;
	logic [7:0] ARR_DATA;
	logic [31:0] rx;
	logic [3:0] oe;
	logic [31:0] ex;
	int len;
	int err_count = 0;
	int compares = 0;
	// ****************************************
	// Clock, array stand-in and instances.
	// ****************************************
	// The clock toggles every half period.
	always #2 REF_CLK = ~REF_CLK;
	// Array data is a fixed function of the address, so misplaced reads show.
	assign ARR_DATA = ARR_ADDR[7:0] ^ 8'h5A;
	sfq_cmd #(.RST_CYCLES(RST_N), .PROG_CYCLES(PROG_N)) dut_u (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
		.SCLK(SCLK), .CS_N(CS_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N),
		.QUAD_ENABLE_BIT(QUAD_ENABLE_BIT), .SECURITY_LOCK_BITS(SECURITY_LOCK_BITS), .STATUS(STATUS),
		.ARR_ADDR(ARR_ADDR), .ARR_DATA(ARR_DATA));
	sfq_host_model host_u (.sclk(SCLK), .cs_n(CS_N), .io_in(IO_IN), .io_out(IO_OUT), .io_oe_n(IO_OE_N));
	// ****************************************
	// Tasks.
	// ****************************************
	// Verdict and end of run.
	task automatic close_out();
	begin
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask : close_out
	// Data compare.
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
	begin
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask : chk_val
	// Status compare under a mask of the fields that matter.
	task automatic chk_st(input logic [7:0] msk, input logic [7:0] exp);
	begin
		chk_val({24'h0, STATUS & msk}, {24'h0, exp});
	end
	endtask : chk_st
	// One link frame.
	task automatic fr(input bit quad, input logic [63:0] tx, input int ntx, input int ndum, input int nrd);
	begin
		host_u.frame(quad, tx, ntx, ndum, nrd, rx, oe);
	end
	endtask : fr
	// Bounded wait for busy to drop; a hang ends the run.
	task automatic wait_idle();
		int n;
	begin
		n = 0;
		while (STATUS.busy !== 1'b0 && n < 5000)
		begin
			@(posedge REF_CLK);
			n++;
		end
		if (n == 5000)
		begin
			err_count++;
			close_out();
		end
	end
	endtask : wait_idle
	// ****************************************
	// Sequence.
	// ****************************************
	initial
	begin
		// A real rising reset edge is needed, since the link-side flops clear asynchronously.
		SYS_RST <= 1'b1;
		repeat (10) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		chk_st(8'hFF, 8'h00);
		fr(0, {OP_SREAD, 24'h001000}, 4, 8, 1);
		chk_val(rx, 32'hFF);
		chk_val({28'h0, oe}, 32'hD);
		// Program without the latch must do nothing.
		fr(0, {OP_PROG, 24'h001000, 8'h12}, 5, 0, 0);
		chk_st(8'hFF, 8'h00);
		fr(0, OP_WREN, 1, 0, 0);
		fr(0, {OP_PROG, 24'h0010FE, 16'hA53C}, 6, 0, 0);
		chk_st(8'hC0, 8'hC0);
		wait_idle();
		chk_st(8'hFF, 8'h00);
		fr(0, {OP_SREAD, 24'h0010FE}, 4, 8, 3);
		chk_val(rx, 32'h00A53CFF);
		// Locked register and a bad register number are both ignored.
		@(posedge REF_CLK) SECURITY_LOCK_BITS <= 3'h2;
		fr(0, OP_WREN, 1, 0, 0);
		fr(0, {OP_PROG, 24'h002000, 8'h00}, 5, 0, 0);
		chk_st(8'hFF, 8'h40);
		fr(0, {OP_PROG, 24'h004000, 8'h00}, 5, 0, 0);
		chk_st(8'hFF, 8'h40);
		// A read issued during a program is ignored and the program completes.
		fr(0, {OP_PROG, 24'h003000, 8'h00}, 5, 0, 0);
		fr(0, {OP_SREAD, 24'h003000}, 4, 8, 1);
		chk_val({28'h0, oe}, 32'hF);
		wait_idle();
		fr(0, {OP_SREAD, 24'h003000}, 4, 8, 1);
		chk_val(rx, 32'h00);
		// Mode entry needs the quad enable bit; latch and wrap survive it.
		fr(0, OP_QPI_ON, 1, 0, 0);
		chk_st(8'hFF, 8'h00);
		fr(0, {OP_WRAPSET, 24'h000000, 8'h20}, 5, 0, 0);
		chk_st(8'hFF, 8'h02);
		fr(0, OP_WREN, 1, 0, 0);
		@(posedge REF_CLK) QUAD_ENABLE_BIT <= 1'b1;
		fr(0, OP_QPI_ON, 1, 0, 0);
		chk_st(8'hF3, 8'h62);
		// Every dummy and wrap code, each tried with 0Ch and with one of 0Bh or EBh.
		for (int d = 0; d < 4; d++)
		begin
			fr(1, {OP_PARAM, 2'h0, 2'(d), 2'h0, 2'(d)}, 2, 0, 0);
			chk_st(8'hFF, 8'h60 | 8'(d * 5));
			fr(1, {d[0] ? OP_QIO : OP_FAST, 24'h000010 + 24'(d)}, 4, 2 * d + 2, 1);
			chk_val(rx, 32'((8'h10 + 8'(d)) ^ 8'h5A));
			len = 8 << d;
			fr(1, {OP_WRAPRD, 24'h000100 + 24'(len - 2)}, 4, 2 * d + 2, 4);
			ex = {8'(len - 2), 8'(len - 1), 8'h00, 8'h01} ^ 32'h5A5A5A5A;
			chk_val(rx, ex);
		end
		fr(1, OP_QPI_OFF, 1, 0, 0);
		chk_st(8'hF3, 8'h43);
		fr(0, {OP_PARAM, 8'h00}, 2, 0, 0);
		chk_st(8'hF3, 8'h43);
		fr(0, {OP_FAST, 24'h000020}, 4, 8, 1);
		chk_val(rx, 32'h7A);
		// Another command between arm and reset disarms it.
		fr(0, OP_RST_EN, 1, 0, 0);
		chk_st(8'h10, 8'h10);
		fr(0, OP_WREN, 1, 0, 0);
		fr(0, OP_RST, 1, 0, 0);
		chk_st(8'hD3, 8'h43);
		fr(0, OP_RST_EN, 1, 0, 0);
		fr(0, OP_RST, 1, 0, 0);
		chk_st(8'h80, 8'h80);
		fr(0, OP_WREN, 1, 0, 0);
		wait_idle();
		chk_st(8'hFF, 8'h00);
		close_out();
	end
endmodule : sfq_cmd_test
